// ### src/scop_pkg.sv
/*
  shared constants and types for the stack and carry-or execution block.
  assumes one core clock, where one machine cycle is one clock cycle.
*/
`default_nettype none

package scop_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_OR_BIT = 8'h72;
  localparam logic [7:0] OPC_OR_NBIT = 8'hA0;
  localparam logic [7:0] OPC_POP = 8'hD0;
  localparam logic [7:0] OPC_PUSH = 8'hC0;
  localparam logic [7:0] OPC_SUB_EXIT = 8'h22;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int SP_W = 8;
  localparam int PC_W = 16;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] SP_DIR_ADDR_DFLT = 8'hFE;

  // ---------------------------------------------------------------
  // sequencer states and instruction kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCOP_IDLE = 2'b00,
    SCOP_MC1 = 2'b01,
    SCOP_MC2 = 2'b10
  } scop_state_t;

  typedef enum logic [2:0] {
    SCOP_K_ORB = 3'b000,
    SCOP_K_ORNB = 3'b001,
    SCOP_K_POP = 3'b010,
    SCOP_K_PUSH = 3'b011,
    SCOP_K_EXIT = 3'b100
  } scop_kind_t;

endpackage

`default_nettype wire

// ### src/scop_sp_if.sv
/*
  control link between the sequencer and the stack pointer unit.
  assumes at most one of inc, dec and load is high in a cycle.
*/
`default_nettype none

interface scop_sp_if;
  logic inc;
  logic dec;
  logic load;
  logic [7:0] load_val;
  logic [7:0] value;

  modport ctl (output inc, output dec, output load, output load_val, input value);
  modport unit (input inc, input dec, input load, input load_val, output value);
endinterface

`default_nettype wire

// ### src/scop_sp_unit.sv
/*
  stack pointer register with increment, decrement and load.
  assumes the controller never asks for two operations at once.
*/
`default_nettype none

module scop_sp_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control
  scop_sp_if.unit sp
);

  logic [7:0] value;
  logic [7:0] next_value;

  // ---------------------------------------------------------------
  // update, plain 8-bit arithmetic so it wraps at 256
  // ---------------------------------------------------------------
  assign next_value = sp.load ? sp.load_val :
                      sp.inc ? value + scop_pkg::SP_STEP :
                      sp.dec ? value - scop_pkg::SP_STEP : value;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value <= scop_pkg::SP_RST;
    end else begin
      value <= next_value;
    end
  end

  assign sp.value = value;

endmodule

`default_nettype wire

// ### src/scop_exec.sv
/*
  execution of carry-or on a bit, stack pop, stack push and subroutine return.
  assumes the decoder hands over opcode and second byte with a start pulse,
  and that ram, direct space and bit space answer reads in the same cycle.
*/
// Notes on behaviour
// - carry-or sets carry when addressed bit is one
// - complemented form uses inverted bit, source untouched
// - carry-or changes no flag but carry
// - carry-or: two bytes, two machine cycles
// - pop reads ram at pointer, decrements, writes direct
// - pop opcode D0, two bytes, two cycles
// - pop into pointer: decrement first, then load
// - push increments pointer, then stores direct byte
// - push opcode C0, two bytes, two cycles
// - return pops high then low, pointer minus two
// - return resumes at restored address, two cycles
// - return leaves all flags unchanged
`default_nettype none

module scop_exec #(
  parameter logic [7:0] SP_DIR_ADDR = scop_pkg::SP_DIR_ADDR_DFLT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // instruction from decoder
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_in,
  output logic busy_out,
  output logic done_out,
  // carry flag
  input wire logic carry_in,
  output logic carry_we_out,
  output logic carry_wdata_out,
  // bit space
  output logic bit_rd_out,
  output logic [7:0] bit_addr_out,
  input wire logic bit_val_in,
  // internal ram
  output logic ram_rd_out,
  output logic ram_wr_out,
  output logic [7:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  input wire logic [7:0] ram_rdata_in,
  // direct space
  output logic dir_rd_out,
  output logic dir_wr_out,
  output logic [7:0] dir_addr_out,
  output logic [7:0] dir_wdata_out,
  input wire logic [7:0] dir_rdata_in,
  // program flow
  output logic pc_load_out,
  output logic [15:0] program_counter_out,
  output logic [7:0] stack_pointer_out
);

  scop_sp_if sp_if ();

  scop_sp_unit u_sp (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sp(sp_if.unit)
  );

  scop_pkg::scop_state_t state;
  scop_pkg::scop_kind_t kind;
  scop_pkg::scop_kind_t dec_kind;
  logic [7:0] operand;
  logic [7:0] data_q;
  logic [7:0] pch;
  logic carry_new;
  logic known;
  logic take;
  logic in1;
  logic in2;
  logic is_or;
  logic is_pop;
  logic is_push;
  logic is_exit;
  logic sp_dst;
  logic src_bit;
  logic [7:0] push_src;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign known = (opcode_in == scop_pkg::OPC_OR_BIT) || (opcode_in == scop_pkg::OPC_OR_NBIT) ||
                 (opcode_in == scop_pkg::OPC_POP) || (opcode_in == scop_pkg::OPC_PUSH) ||
                 (opcode_in == scop_pkg::OPC_SUB_EXIT);
  assign dec_kind = (opcode_in == scop_pkg::OPC_OR_BIT) ? scop_pkg::SCOP_K_ORB :
                    (opcode_in == scop_pkg::OPC_OR_NBIT) ? scop_pkg::SCOP_K_ORNB :
                    (opcode_in == scop_pkg::OPC_POP) ? scop_pkg::SCOP_K_POP :
                    (opcode_in == scop_pkg::OPC_PUSH) ? scop_pkg::SCOP_K_PUSH :
                    scop_pkg::SCOP_K_EXIT;
  // unknown opcodes are left for other execution units, no busy shown
  assign take = start_in && known && (state == scop_pkg::SCOP_IDLE);
  assign in1 = (state == scop_pkg::SCOP_MC1);
  assign in2 = (state == scop_pkg::SCOP_MC2);
  assign is_or = (kind == scop_pkg::SCOP_K_ORB) || (kind == scop_pkg::SCOP_K_ORNB);
  assign is_pop = (kind == scop_pkg::SCOP_K_POP);
  assign is_push = (kind == scop_pkg::SCOP_K_PUSH);
  assign is_exit = (kind == scop_pkg::SCOP_K_EXIT);
  assign sp_dst = (operand == SP_DIR_ADDR);
  // inversion only on the copy, bit space sees a read only
  assign src_bit = (kind == scop_pkg::SCOP_K_ORNB) ? ~bit_val_in : bit_val_in;
  // pushing the pointer itself stores its already incremented value
  assign push_src = sp_dst ? sp_if.value + scop_pkg::SP_STEP : dir_rdata_in;

  // ---------------------------------------------------------------
  // sequencer, two machine cycles for every kind
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= scop_pkg::SCOP_IDLE;
    end else begin
      case (state)
        scop_pkg::SCOP_IDLE: state <= take ? scop_pkg::SCOP_MC1 : scop_pkg::SCOP_IDLE;
        scop_pkg::SCOP_MC1: state <= scop_pkg::SCOP_MC2;
        scop_pkg::SCOP_MC2: state <= scop_pkg::SCOP_IDLE;
        default: state <= scop_pkg::SCOP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kind <= scop_pkg::SCOP_K_ORB;
      operand <= 8'h00;
    end else if (take) begin
      kind <= dec_kind;
      operand <= operand_in;
    end
  end

  // ---------------------------------------------------------------
  // data capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_q <= 8'h00;
      pch <= 8'h00;
      carry_new <= 1'b0;
      program_counter_out <= 16'h0000;
      pc_load_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      if (in1 && is_or) begin
        carry_new <= carry_in | src_bit;
      end
      if (in1 && is_pop) begin
        data_q <= ram_rdata_in;
      end
      if (in1 && is_push) begin
        data_q <= push_src;
      end
      if (in1 && is_exit) begin
        pch <= ram_rdata_in;
      end
      if (in2 && is_exit) begin
        program_counter_out <= {pch, ram_rdata_in};
      end
      pc_load_out <= in2 && is_exit;
      done_out <= in2;
    end
  end

  // ---------------------------------------------------------------
  // outputs and pointer control
  // ---------------------------------------------------------------
  assign busy_out = (state != scop_pkg::SCOP_IDLE);
  // carry is the only flag this block can write
  assign carry_we_out = in2 && is_or;
  assign carry_wdata_out = carry_new;
  assign bit_rd_out = in1 && is_or;
  assign bit_addr_out = operand;
  assign ram_rd_out = (in1 && (is_pop || is_exit)) || (in2 && is_exit);
  assign ram_wr_out = in2 && is_push;
  assign ram_addr_out = sp_if.value;
  assign ram_wdata_out = data_q;
  assign dir_rd_out = in1 && is_push && !sp_dst;
  assign dir_wr_out = in2 && is_pop && !sp_dst;
  assign dir_addr_out = operand;
  assign dir_wdata_out = data_q;
  assign stack_pointer_out = sp_if.value;
  assign sp_if.inc = in1 && is_push;
  assign sp_if.dec = (in1 && (is_pop || is_exit)) || (in2 && is_exit);
  // the decrement already happened in the first cycle, load wins after it
  assign sp_if.load = in2 && is_pop && sp_dst;
  assign sp_if.load_val = data_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_or_set;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && kind == scop_pkg::SCOP_K_ORB) |=>
      carry_we_out && (carry_wdata_out == ($past(carry_in) | $past(bit_val_in)));
  endproperty
  a_or_set: assert property (p_or_set) else $error("carry-or result wrong");

  property p_or_inv;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && kind == scop_pkg::SCOP_K_ORNB) |=>
      carry_we_out && (carry_wdata_out == ($past(carry_in) | ~$past(bit_val_in)));
  endproperty
  a_or_inv: assert property (p_or_inv) else $error("complemented carry-or wrong");

  property p_flag_only_or;
    @(posedge clk_in) disable iff (!rst_b_in)
    carry_we_out |-> is_or && in2 && $past(bit_rd_out);
  endproperty
  a_flag_only_or: assert property (p_flag_only_or) else $error("flag written by wrong kind");

  property p_two_cycles;
    @(posedge clk_in) disable iff (!rst_b_in)
    take |=> in1 ##1 in2 ##1 (done_out && !busy_out);
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("instruction not two cycles");

  property p_pop_dec;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && is_pop && !sp_dst) |=> dir_wr_out && (sp_if.value == 8'($past(sp_if.value) - 8'h01));
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop pointer not decremented");

  property p_pop_self;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && is_pop && sp_dst) |=> ##1 (sp_if.value == $past(ram_rdata_in, 2));
  endproperty
  a_pop_self: assert property (p_pop_self) else $error("pop into pointer wrong");

  property p_push_addr;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && is_push) |=> ram_wr_out && (ram_addr_out == 8'($past(sp_if.value) + 8'h01));
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong");

  property p_exit_sp;
    @(posedge clk_in) disable iff (!rst_b_in)
    (in1 && is_exit) |=> ##1 (sp_if.value == 8'($past(sp_if.value, 2) - 8'h02));
  endproperty
  a_exit_sp: assert property (p_exit_sp) else $error("return pointer not minus two");

  property p_exit_pc;
    @(posedge clk_in) disable iff (!rst_b_in)
    pc_load_out |-> program_counter_out == {$past(ram_rdata_in, 2), $past(ram_rdata_in)};
  endproperty
  a_exit_pc: assert property (p_exit_pc) else $error("return address wrong");

endmodule

`default_nettype wire

// ### verification/tb_top.sv
/*
  self-checking bench for the stack and carry-or execution block.
  assumes starts are taken when idle, done comes three edges later and
  reads are answered in the strobe cycle; the bench stands for ram, direct
  space, bit space and carry owner.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] opc;
    logic [7:0] a;
    logic [7:0] sp;
    logic c;
    logic [15:0] v;
  } scop_note_t;

  // ---------------------------------------------------------------
  // signals, memories and expectations
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start_in = 1'b0;
  logic carry_in = 1'b0;
  logic clr_c = 1'b0;
  logic [7:0] opcode_in = 8'h00;
  logic [7:0] operand_in = 8'h00;
  logic bit_val_in, busy_out, done_out, carry_we_out, carry_wdata_out, bit_rd_out;
  logic ram_rd_out, ram_wr_out, dir_rd_out, dir_wr_out, pc_load_out;
  logic [7:0] bit_addr_out, ram_addr_out, ram_wdata_out, ram_rdata_in;
  logic [7:0] dir_addr_out, dir_wdata_out, dir_rdata_in, stack_pointer_out;
  logic [15:0] program_counter_out;
  logic [7:0] ram [256];
  logic [7:0] dirm [256];
  logic [7:0] e_ram [256];
  logic [7:0] e_dir [256];
  logic bits [256];
  logic [7:0] e_sp;
  logic e_c;
  scop_note_t q [$];
  scop_note_t n;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 clk_in = ~clk_in;

  scop_exec dut (.clk_in, .rst_b_in, .start_in, .opcode_in, .operand_in, .busy_out, .done_out,
    .carry_in, .carry_we_out, .carry_wdata_out, .bit_rd_out, .bit_addr_out, .bit_val_in,
    .ram_rd_out, .ram_wr_out, .ram_addr_out, .ram_wdata_out, .ram_rdata_in, .dir_rd_out,
    .dir_wr_out, .dir_addr_out, .dir_wdata_out, .dir_rdata_in, .pc_load_out,
    .program_counter_out, .stack_pointer_out);

  // ---------------------------------------------------------------
  // far side: unselected reads show the inverse, never a stale value
  // ---------------------------------------------------------------
  assign ram_rdata_in = ram_rd_out ? ram[ram_addr_out] : ~ram[ram_addr_out];
  assign dir_rdata_in = dir_rd_out ? dirm[dir_addr_out] : ~dirm[dir_addr_out];
  assign bit_val_in = bit_rd_out ? bits[bit_addr_out] : ~bits[bit_addr_out];

  always @(posedge clk_in) begin
    if (ram_wr_out === 1'b1) ram[ram_addr_out] <= ram_wdata_out;
    if (dir_wr_out === 1'b1) dirm[dir_addr_out] <= dir_wdata_out;
    if (carry_we_out === 1'b1) carry_in <= carry_wdata_out;
    else if (clr_c) carry_in <= 1'b0;
    cycles <= cycles + 1;
    if (cycles == 2500) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // issue one instruction; hold keeps start up into the busy cycle
  // ---------------------------------------------------------------
  task automatic op(input logic [7:0] opc, input logic [7:0] a, input bit hold);
    logic ok;
    logic [7:0] hi;
    scop_note_t m;
    ok = opc inside {scop_pkg::OPC_OR_BIT, scop_pkg::OPC_OR_NBIT, scop_pkg::OPC_POP,
      scop_pkg::OPC_PUSH, scop_pkg::OPC_SUB_EXIT};
    // carry owner clears on the taking edge, before cycle 1 samples it
    if ($urandom_range(3) == 0) begin
      clr_c = 1'b1;
      e_c = 1'b0;
    end
    start_in = 1'b1;
    opcode_in = opc;
    operand_in = a;
    @(posedge clk_in);
    #1;
    clr_c = 1'b0;
    chk("busy", {15'h0000, busy_out}, {15'h0000, ok});
    m.v = 16'h0000;
    if (opc == scop_pkg::OPC_OR_BIT && ok) e_c = e_c | bits[a];
    if (opc == scop_pkg::OPC_OR_NBIT) e_c = e_c | ~bits[a];
    if (opc == scop_pkg::OPC_POP) begin
      m.v = {8'h00, e_ram[e_sp]};
      e_sp = e_sp - 8'h01;
      if (a == scop_pkg::SP_DIR_ADDR_DFLT) e_sp = m.v[7:0];
      else e_dir[a] = m.v[7:0];
    end
    if (opc == scop_pkg::OPC_PUSH) begin
      e_sp = e_sp + 8'h01;
      m.v = {8'h00, (a == scop_pkg::SP_DIR_ADDR_DFLT) ? e_sp : e_dir[a]};
      e_ram[e_sp] = m.v[7:0];
    end
    if (opc == scop_pkg::OPC_SUB_EXIT) begin
      hi = e_ram[e_sp];
      e_sp = e_sp - 8'h01;
      m.v = {hi, e_ram[e_sp]};
      e_sp = e_sp - 8'h01;
    end
    m.opc = opc;
    m.a = a;
    m.sp = e_sp;
    m.c = e_c;
    if (ok) q.push_back(m);
    if (hold) begin
      @(posedge clk_in);
      #1;
    end
    start_in = 1'b0;
    if (!hold) @(posedge clk_in);
    @(posedge clk_in);
    #1;
    chk("done", {15'h0000, done_out}, {15'h0000, ok});
  endtask

  // ---------------------------------------------------------------
  // monitor: oldest note against the settled outputs
  // ---------------------------------------------------------------
  always @(negedge clk_in) begin
    if (done_out === 1'b1 && q.size() == 0) chk("spare_done", 16'h0001, 16'h0000);
    else if (done_out === 1'b1) begin
      n = q.pop_front();
      chk("sp", {8'h00, stack_pointer_out}, {8'h00, n.sp});
      chk("carry", {15'h0000, carry_in}, {15'h0000, n.c});
      chk("pc_load", {15'h0000, pc_load_out}, {15'h0000, n.opc == scop_pkg::OPC_SUB_EXIT});
      if (n.opc == scop_pkg::OPC_POP && n.a != scop_pkg::SP_DIR_ADDR_DFLT)
        chk("pop", {8'h00, dirm[n.a]}, n.v);
      if (n.opc == scop_pkg::OPC_PUSH) chk("push", {8'h00, ram[n.sp]}, n.v);
      if (n.opc == scop_pkg::OPC_SUB_EXIT) chk("pc", program_counter_out, n.v);
    end
  end

  initial begin
    logic [7:0] tbl [6];
    tbl = '{scop_pkg::OPC_OR_BIT, scop_pkg::OPC_OR_NBIT, scop_pkg::OPC_POP, scop_pkg::OPC_PUSH,
      scop_pkg::OPC_SUB_EXIT, 8'h32};
    void'($urandom(17591));
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'($urandom);
      dirm[i] = 8'($urandom);
      bits[i] = 1'($urandom);
    end
    e_ram = ram;
    e_dir = dirm;
    e_sp = scop_pkg::SP_RST;
    e_c = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    chk("sp_rst", {8'h00, stack_pointer_out}, {8'h00, scop_pkg::SP_RST});
    chk("busy_rst", {15'h0000, busy_out}, 16'h0000);
    op(scop_pkg::OPC_POP, 8'h10, 1'b0);
    op(scop_pkg::OPC_PUSH, 8'h11, 1'b0);
    op(scop_pkg::OPC_POP, scop_pkg::SP_DIR_ADDR_DFLT, 1'b0);
    op(8'h32, 8'h00, 1'b0);
    op(scop_pkg::OPC_PUSH, 8'h20, 1'b1);
    for (int i = 0; i < 180; i++) begin
      op(tbl[$urandom_range(5)], ($urandom_range(9) == 0) ? scop_pkg::SP_DIR_ADDR_DFLT :
        8'($urandom_range(253)), $urandom_range(4) == 0);
    end
    repeat (3) @(posedge clk_in);
    chk("left", 16'(q.size()), 16'h0000);
    conclude();
  end
endmodule

`default_nettype wire
